// ### vb_map.vh
// vb_map.vh: constants of the video buffer i2c control block.
// assumes inclusion by bare name from every design file that needs it.
`ifndef VB_MAP_VH
`define VB_MAP_VH

// slave address prefix, bits 7..3 of the address byte
`define VB_ADDR_PREFIX 5'h0B

// subaddresses
`define VB_SUB_CH1 8'h01
`define VB_SUB_CH2 8'h02
`define VB_SUB_CH3 8'h03
`define VB_SUB_SYNC 8'h04

// channel register fields
`define VB_CH_CLAMP_BIT 7
`define VB_CH_MUX_HI 6
`define VB_CH_MUX_LO 3
`define VB_CH_OP_HI 2
`define VB_CH_OP_LO 0
`define VB_MUX_LAST_A 4'h4
`define VB_MUX_LAST_B 4'h9

// operation codes of a channel register
`define VB_OP_OFF 3'h0
`define VB_OP_MUTE 3'h1
`define VB_OP_DC 3'h2
`define VB_OP_DC_SHIFT 3'h3
`define VB_OP_AC_BIAS 3'h4
`define VB_OP_STC_LOW 3'h5
`define VB_OP_STC_MID 3'h6
`define VB_OP_STC_HIGH 3'h7

// sync and global disable register fields
`define VB_SY_MON_BIT 6
`define VB_SY_BUF_BIT 5
`define VB_SY_V_HI 4
`define VB_SY_V_LO 3
`define VB_SY_H_HI 2
`define VB_SY_H_LO 1
`define VB_SY_EN_BIT 0
`define VB_SY_SEL_B 2'h1

// power-up values, chosen by the power-up configuration pin
`define VB_CH_PUC_LO 8'h00
`define VB_CH_PUC_HI 8'h04
`define VB_SY_PUC_LO 8'h00
`define VB_SY_PUC_HI 8'h40

// timing counts: init wait in ref_clk_i cycles, byte length in scl bits
`define VB_INIT_WAIT 2'h3
`define VB_BYTE_BITS 4'h8

// synchroniser reset value: bus idle high
`define VB_SYNC_W 5
`define VB_SYNC_RST 5'h1F

`endif

// ### vb_sync2.v
// vb_sync2.v: two-flop synchroniser for pin inputs.
// assumes inputs are asynchronous to ref_clk_i.
`timescale 1ns/10ps
`include "vb_map.vh"

module vb_sync2 (
    input wire ref_clk_i,
    input wire rst_i,
    input wire [`VB_SYNC_W-1:0] async_i,
    output wire [`VB_SYNC_W-1:0] sync_o
);

reg [`VB_SYNC_W-1:0] meta_q;
reg [`VB_SYNC_W-1:0] sync_q;

always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        meta_q <= `VB_SYNC_RST;
        sync_q <= `VB_SYNC_RST;
    end
    else
    begin
        meta_q <= async_i;
        sync_q <= meta_q;
    end
end

assign sync_o = sync_q;

endmodule // vb_sync2

// ### vb_chan_dec.v
// vb_chan_dec.v: field decoder of one analog channel register.
// assumes global enables come from the sync register; purely combinational.
`timescale 1ns/10ps
`include "vb_map.vh"

module vb_chan_dec (
    input wire [7:0] cfg_i,
    input wire mon_all_i,
    input wire buf_all_i,
    output wire tip_clamp_o,
    output wire mux_b_o,
    output wire mon_en_o,
    output wire buf_en_o,
    output wire mute_o,
    output wire [2:0] in_mode_o
);

wire [3:0] mux_code;
wire [2:0] op;
wire active;

assign mux_code = cfg_i[`VB_CH_MUX_HI:`VB_CH_MUX_LO];
assign op = cfg_i[`VB_CH_OP_HI:`VB_CH_OP_LO];
// 0 low bandwidth, 1 high bandwidth clamp filter
assign tip_clamp_o = cfg_i[`VB_CH_CLAMP_BIT];
// reserved mux codes fall back to input a
assign mux_b_o = (mux_code > `VB_MUX_LAST_A) && (mux_code <= `VB_MUX_LAST_B);
assign active = (op != `VB_OP_OFF) && (op != `VB_OP_MUTE);
assign mute_o = (op == `VB_OP_MUTE);
// global disables override the channel code
assign mon_en_o = active & mon_all_i;
assign buf_en_o = active & buf_all_i;
// codes 010..111 pass through as the input mode
assign in_mode_o = active ? op : `VB_OP_OFF;

endmodule // vb_chan_dec

// ### vb_i2c_ctrl.v
// vb_i2c_ctrl.v: i2c slave control of a three-channel video buffer.
// assumes scl/sda are resolved open-drain wires far slower than ref_clk_i.
`timescale 1ns/10ps
`include "vb_map.vh"

module vb_i2c_ctrl (
    input wire ref_clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_n_o,
    input wire addr_select_high_i,
    input wire addr_select_low_i,
    input wire power_up_config_pin_i,
    output reg cfg_ready_o,
    output reg [2:0] tip_clamp_o,
    output reg [2:0] mux_b_o,
    output reg [2:0] mon_en_o,
    output reg [2:0] buf_en_o,
    output reg [2:0] mute_o,
    output reg [8:0] in_mode_o,
    output reg vsync_mux_b_o,
    output reg hsync_mux_b_o,
    output reg sync_en_o
);

localparam [8:0] ST_INIT = 9'h001;
localparam [8:0] ST_IDLE = 9'h002;
localparam [8:0] ST_ADDR = 9'h004;
localparam [8:0] ST_AACK = 9'h008;
localparam [8:0] ST_SUB = 9'h010;
localparam [8:0] ST_SACK = 9'h020;
localparam [8:0] ST_DATA = 9'h040;
localparam [8:0] ST_DACK = 9'h080;
localparam [8:0] ST_RD = 9'h100;

// prefix is fixed, select bits compared on every address byte
function addr_hit;
    input [6:0] addr;
    input sel_hi;
    input sel_lo;
    begin
        addr_hit = (addr == {`VB_ADDR_PREFIX, sel_hi, sel_lo});
    end
endfunction

function sub_ok;
    input [7:0] sub;
    begin
        sub_ok = (sub >= `VB_SUB_CH1) && (sub <= `VB_SUB_SYNC);
    end
endfunction

function [1:0] sub_index;
    input [7:0] sub;
    begin
        case (sub)
            `VB_SUB_CH1: sub_index = 2'h0;
            `VB_SUB_CH2: sub_index = 2'h1;
            `VB_SUB_CH3: sub_index = 2'h2;
            default: sub_index = 2'h3;
        endcase
    end
endfunction

wire [`VB_SYNC_W-1:0] pins_s;
wire scl_s;
wire sda_s;
wire sel_hi_s;
wire sel_lo_s;
wire puc_s;

vb_sync2 u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({scl_i, sda_i, addr_select_high_i, addr_select_low_i, power_up_config_pin_i}),
    .sync_o(pins_s)
);

assign scl_s = pins_s[4];
assign sda_s = pins_s[3];
assign sel_hi_s = pins_s[2];
assign sel_lo_s = pins_s[1];
assign puc_s = pins_s[0];

reg scl_q;
reg sda_q;
reg [8:0] st_q;
reg [1:0] init_cnt_q;
reg [3:0] bcnt_q;
reg [7:0] shift_q;
reg [7:0] tx_q;
reg [7:0] sub_q;
reg rw_q;
reg drv_q;
reg [7:0] cfg_q [0:3];
integer i;

wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire byte_full;
wire [7:0] rd_byte;

assign scl_rise = scl_s & ~scl_q;
assign scl_fall = ~scl_s & scl_q;
// sda may only move while scl is low, except for start and stop
assign start_det = scl_s & scl_q & sda_q & ~sda_s;
assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
assign byte_full = (bcnt_q == `VB_BYTE_BITS);
// unmapped subaddress reads back as zero
assign rd_byte = sub_ok(sub_q) ? cfg_q[sub_index(sub_q)] : 8'h00;

always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        scl_q <= 1'b1;
        sda_q <= 1'b1;
    end
    else
    begin
        scl_q <= scl_s;
        sda_q <= sda_s;
    end
end

always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        st_q <= ST_INIT;
        init_cnt_q <= 2'h0;
        bcnt_q <= 4'h0;
        shift_q <= 8'h00;
        tx_q <= 8'h00;
        sub_q <= 8'h00;
        rw_q <= 1'b0;
        drv_q <= 1'b0;
        for (i = 0; i < 4; i = i + 1)
        begin
            cfg_q[i] <= 8'h00;
        end
    end
    else if (st_q == ST_INIT)
    begin
        // strap is read only once the synchroniser has settled
        init_cnt_q <= init_cnt_q + 2'h1;
        if (init_cnt_q == `VB_INIT_WAIT)
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                cfg_q[i] <= puc_s ? `VB_CH_PUC_HI : `VB_CH_PUC_LO;
            end
            cfg_q[3] <= puc_s ? `VB_SY_PUC_HI : `VB_SY_PUC_LO;
            st_q <= ST_IDLE;
        end
    end
    else if (start_det)
    begin
        // repeated start also restarts address reception
        st_q <= ST_ADDR;
        bcnt_q <= 4'h0;
        drv_q <= 1'b0;
    end
    else if (stop_det)
    begin
        // a stop before the data ack leaves registers untouched
        st_q <= ST_IDLE;
        drv_q <= 1'b0;
    end
    else
    begin
        if (scl_rise)
        begin
            shift_q <= {shift_q[6:0], sda_s};
            bcnt_q <= bcnt_q + 4'h1;
        end
        if (scl_fall)
        begin
            case (st_q)
                ST_IDLE:
                begin
                    drv_q <= 1'b0;
                end
                ST_ADDR:
                begin
                    if (byte_full)
                    begin
                        if (addr_hit(shift_q[7:1], sel_hi_s, sel_lo_s))
                        begin
                            rw_q <= shift_q[0];
                            drv_q <= 1'b1;
                            st_q <= ST_AACK;
                        end
                        else
                        begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_AACK:
                begin
                    bcnt_q <= 4'h0;
                    if (rw_q)
                    begin
                        // subaddress kept from the earlier write phase
                        tx_q <= {rd_byte[6:0], 1'b0};
                        drv_q <= ~rd_byte[7];
                        st_q <= ST_RD;
                    end
                    else
                    begin
                        drv_q <= 1'b0;
                        st_q <= ST_SUB;
                    end
                end
                ST_SUB:
                begin
                    if (byte_full)
                    begin
                        sub_q <= shift_q;
                        drv_q <= 1'b1;
                        st_q <= ST_SACK;
                    end
                end
                ST_SACK:
                begin
                    bcnt_q <= 4'h0;
                    drv_q <= 1'b0;
                    st_q <= ST_DATA;
                end
                ST_DATA:
                begin
                    if (byte_full)
                    begin
                        tx_q <= shift_q; // held: the ack bit shifts in behind the data
                        drv_q <= 1'b1;
                        st_q <= ST_DACK;
                    end
                end
                ST_DACK:
                begin
                    // commit at the end of the data ack
                    if (sub_ok(sub_q))
                    begin
                        cfg_q[sub_index(sub_q)] <= tx_q;
                    end
                    drv_q <= 1'b0;
                    // further bytes get no ack: no auto-increment
                    st_q <= ST_IDLE;
                end
                ST_RD:
                begin
                    if (byte_full)
                    begin
                        // single byte: master ack ignored, bus released
                        drv_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                    else
                    begin
                        drv_q <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                default:
                begin
                    drv_q <= 1'b0;
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
end

wire mon_all;
wire buf_all;
wire [2:0] dec_clamp;
wire [2:0] dec_mux_b;
wire [2:0] dec_mon;
wire [2:0] dec_buf;
wire [2:0] dec_mute;
wire [8:0] dec_mode;

assign mon_all = cfg_q[3][`VB_SY_MON_BIT];
assign buf_all = cfg_q[3][`VB_SY_BUF_BIT];

genvar g;
generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_chan
        vb_chan_dec u_dec (
            .cfg_i(cfg_q[g]),
            .mon_all_i(mon_all),
            .buf_all_i(buf_all),
            .tip_clamp_o(dec_clamp[g]),
            .mux_b_o(dec_mux_b[g]),
            .mon_en_o(dec_mon[g]),
            .buf_en_o(dec_buf[g]),
            .mute_o(dec_mute[g]),
            .in_mode_o(dec_mode[3*g+2:3*g])
        );
    end
endgenerate

// outputs registered; held at disabled until the strap is taken
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        sda_o <= 1'b0;
        sda_oe_n_o <= 1'b1;
        cfg_ready_o <= 1'b0;
        tip_clamp_o <= 3'h0;
        mux_b_o <= 3'h0;
        mon_en_o <= 3'h0;
        buf_en_o <= 3'h0;
        mute_o <= 3'h0;
        in_mode_o <= 9'h000;
        vsync_mux_b_o <= 1'b0;
        hsync_mux_b_o <= 1'b0;
        sync_en_o <= 1'b0;
    end
    else
    begin
        // open drain: only ever pulls low
        sda_o <= 1'b0;
        sda_oe_n_o <= ~drv_q;
        cfg_ready_o <= (st_q != ST_INIT);
        tip_clamp_o <= dec_clamp;
        mux_b_o <= dec_mux_b;
        mon_en_o <= dec_mon;
        buf_en_o <= dec_buf;
        mute_o <= dec_mute;
        in_mode_o <= dec_mode;
        vsync_mux_b_o <= (cfg_q[3][`VB_SY_V_HI:`VB_SY_V_LO] == `VB_SY_SEL_B);
        hsync_mux_b_o <= (cfg_q[3][`VB_SY_H_HI:`VB_SY_H_LO] == `VB_SY_SEL_B);
        sync_en_o <= cfg_q[3][`VB_SY_EN_BIT];
    end
end

endmodule // vb_i2c_ctrl

// ### vb_i2c_ctrl_sva.sv
// vb_i2c_ctrl_sva.sv: port checker of the video buffer i2c control.
// assumes it is bound to vb_i2c_ctrl and sees its ports only.
`timescale 1ns/10ps
module vb_i2c_ctrl_sva (
    input logic ref_clk_i,
    input logic rst_i,
    input logic scl_i,
    input logic sda_i,
    input logic sda_o,
    input logic sda_oe_n_o,
    input logic addr_select_high_i,
    input logic addr_select_low_i,
    input logic power_up_config_pin_i,
    input logic cfg_ready_o,
    input logic [2:0] tip_clamp_o,
    input logic [2:0] mux_b_o,
    input logic [2:0] mon_en_o,
    input logic [2:0] buf_en_o,
    input logic [2:0] mute_o,
    input logic [8:0] in_mode_o,
    input logic vsync_mux_b_o,
    input logic hsync_mux_b_o,
    input logic sync_en_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] cnt_q;
    wire [26:0] outs = {tip_clamp_o, mux_b_o, mon_en_o, buf_en_o, mute_o, in_mode_o,
        vsync_mux_b_o, hsync_mux_b_o, sync_en_o};
    // saturating count of edges since reset release
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= 3'h0;
        else if (cnt_q != 3'h7)
            cnt_q <= cnt_q + 3'h1;
    end
    sequence s_loaded;
        $rose(cfg_ready_o);
    endsequence
    sequence s_ack_high;
        scl_i && !sda_oe_n_o;
    endsequence
    chk_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
    chk_ready_early: assert property (cnt_q < 3'h4 |-> !cfg_ready_o) else $error("ready early");
    chk_ready_late: assert property (cnt_q == 3'h6 |-> cfg_ready_o) else $error("ready late");
    chk_ready_sticky: assert property (cfg_ready_o |=> cfg_ready_o) else $error("ready dropped");
    chk_puc_state: assert property (s_loaded |-> outs == (power_up_config_pin_i ? 27'h1C0920 : 27'h0))
        else $error("power-up outputs wrong");
    // outputs may only move late in an scl low phase, after a data ack
    chk_change_busy: assert property ($past(cfg_ready_o) && !$stable(outs) |-> !scl_i && !$past(scl_i, 3))
        else $error("outputs moved outside a transfer");
    chk_sda_edge: assert property (!$stable(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
        else $error("sda moved while scl high");
    chk_ack_hold: assert property (s_ack_high |=> !sda_oe_n_o || !scl_i) else $error("ack cut short");
    chk_mute_quiet: assert property ((mute_o & (mon_en_o | buf_en_o)) == 3'h0) else $error("muted path on");
    chk_path_mode: assert property (mon_en_o[0] || buf_en_o[0] |-> in_mode_o[2:0] > 3'h1)
        else $error("path on without mode");
endmodule // vb_i2c_ctrl_sva

// ### vb_i2c_master.sv
// vb_i2c_master.sv: behavioural i2c bus master.
// assumes the bench resolves sda with a pull-up and the device drive.
`timescale 1ns/10ps
module vb_i2c_master (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    int q = 8; // quarter bit; bench varies it for prompt and slow bits
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic start();
        sda_o = 1'b1;
        wt(q);
        scl_o = 1'b1;
        wt(q);
        sda_o = 1'b0;
        wt(q);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        wt(q);
        sda_o = 1'b0;
        wt(q);
        scl_o = 1'b1;
        wt(q);
        sda_o = 1'b1;
        wt(q);
    endtask
    // sda moves only mid-low, so it is stable over the whole high phase
    task automatic bit_io(input logic b, output logic r);
        wt(q);
        sda_o = b;
        wt(q);
        scl_o = 1'b1;
        wt(q);
        r = sda_i;
        wt(q);
        scl_o = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(1'b1, a); // released for ack, nack on reads
        ack = !a;
    endtask
endmodule // vb_i2c_master

// ### testbench.sv
// testbench.sv: self-checking bench of the video buffer i2c control.
// assumes vb_i2c_master as bus partner and the bound port checker.
`timescale 1ns/10ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic addr_select_high_i = 1'b0;
    logic addr_select_low_i = 1'b0;
    logic power_up_config_pin_i = 1'b0;
    wire scl_i;
    wire sda_i;
    wire m_sda;
    wire sda_o;
    wire sda_oe_n_o;
    wire cfg_ready_o;
    wire [2:0] tip_clamp_o, mux_b_o, mon_en_o, buf_en_o, mute_o;
    wire [8:0] in_mode_o;
    wire vsync_mux_b_o, hsync_mux_b_o, sync_en_o;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rs = 32'h712D;
    logic [7:0] mdl [1:4];
    logic [7:0] sy [3] = '{8'h6B, 8'h37, 8'h4A};
    assign sda_i = m_sda & (sda_oe_n_o | sda_o); // wired-and, pull-up
    always #20 ref_clk_i = ~ref_clk_i;
    vb_i2c_ctrl DUT (.*);
    vb_i2c_master mst (.ref_clk_i(ref_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(m_sda));
    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            n_errors++;
            test_done();
        end
    end
    function automatic logic [31:0] rnd();
        rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
        return rs;
    endfunction
    function automatic logic [6:0] own();
        return {5'h0B, addr_select_high_i, addr_select_low_i};
    endfunction
    function automatic logic [26:0] eo();
        logic [2:0] t, x, mo, bu, mu;
        logic [8:0] im;
        logic [7:0] c;
        for (int g = 0; g < 3; g++)
        begin
            c = mdl[g + 1];
            t[g] = c[7];
            x[g] = c[6:3] > 4'h4 && c[6:3] < 4'hA;
            mo[g] = c[2:0] > 3'h1 && mdl[4][6];
            bu[g] = c[2:0] > 3'h1 && mdl[4][5];
            mu[g] = c[2:0] == 3'h1;
            im[3 * g +: 3] = c[2:0] > 3'h1 ? c[2:0] : 3'h0;
        end
        return {t, x, mo, bu, mu, im, mdl[4][4:3] == 2'h1, mdl[4][2:1] == 2'h1, mdl[4][0]};
    endfunction
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic cmp(input string s, input logic [26:0] e, input logic [26:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_bit(input string s, input logic e, input logic g);
        cmp(s, {26'h0, e}, {26'h0, g});
    endtask
    task automatic chk_byte(input string s, input logic [7:0] e, input logic [7:0] g);
        cmp(s, {19'h0, e}, {19'h0, g});
    endtask
    task automatic chk_outs();
        cmp("outputs", eo(), {tip_clamp_o, mux_b_o, mon_en_o, buf_en_o, mute_o, in_mode_o,
            vsync_mux_b_o, hsync_mux_b_o, sync_en_o});
    endtask
    // n: bytes after the address; 1 stops after the subaddress
    task automatic wr(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d, input logic ea, input int n);
        logic k;
        logic [7:0] r;
        mst.q = 5 + int'(rnd() % 6);
        mst.start();
        mst.xfer({a, 1'b0}, r, k);
        chk_bit("address ack", ea, k);
        for (int i = 0; i < n && ea; i++)
        begin
            mst.xfer(i == 0 ? s : d, r, k);
            chk_bit("byte ack", i < 2, k);
        end
        mst.stop();
        if (ea && n > 1 && s > 8'h0 && s < 8'h5)
            mdl[s[2:0]] = d;
        wt(4);
        chk_outs();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] s);
        logic k;
        logic [7:0] r;
        wr(a, s, 8'h00, 1'b1, 1);
        mst.start();
        mst.xfer({a, 1'b1}, r, k);
        chk_bit("read address ack", 1'b1, k);
        mst.xfer(8'hFF, r, k);
        mst.stop();
        chk_byte("read data", (s > 8'h0 && s < 8'h5) ? mdl[s[2:0]] : 8'h00, r);
    endtask
    task automatic boot(input logic p);
        rst_i = 1'b1;
        power_up_config_pin_i = p;
        wt(3);
        rst_i = 1'b0;
        wt(8);
        for (int i = 1; i < 4; i++)
            mdl[i] = p ? 8'h04 : 8'h00;
        mdl[4] = p ? 8'h40 : 8'h00;
        chk_bit("ready", 1'b1, cfg_ready_o);
        chk_outs();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        logic [7:0] s;
        boot(1'b0);
        rd(own(), 8'h03);
        $display("test strap low done");
        boot(1'b1);
        wr({5'h0A, 2'h0}, 8'h01, 8'h5D, 1'b0, 2);
        wr({5'h1B, 2'h0}, 8'h01, 8'h5D, 1'b0, 2);
        // mismatching selects first, so power-up state must still stand
        for (int i = 7; i >= 0; i--)
        begin
            {addr_select_high_i, addr_select_low_i} = i[1:0];
            wr(i[2] ? {5'h0B, ~i[1:0]} : own(), 8'h01, 8'h5D, !i[2], 2);
        end
        $display("test address done");
        for (int op = 0; op < 8; op++)
            wr(own(), 8'(op % 3 + 1), {op[0], 4'h4 + op[3:0], op[2:0]}, 1'b1, 2);
        for (int j = 0; j < 3; j++)
            wr(own(), 8'h04, sy[j], 1'b1, 2);
        wr(own(), 8'h02, 8'hC6, 1'b1, 3);
        rd(own(), 8'h07);
        $display("test fields done");
        for (int j = 0; j < 14; j++)
        begin
            s = 8'(rnd() % 6);
            {addr_select_high_i, addr_select_low_i} = 2'(rnd());
            wr(own(), s, 8'(rnd()), 1'b1, 2);
            if (j % 3 == 0)
                rd(own(), s);
        end
        $display("test random done");
        boot(1'b1);
        $display("test second reset done");
        test_done();
    end
endmodule // testbench
bind vb_i2c_ctrl vb_i2c_ctrl_sva chk (.*);
